// ---- logic/bil_pkg.sv ----
package bil_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RST_SEQ_US = 20;
  localparam int RST_SEQ_CYC = (RST_SEQ_US * (CLK_HZ / 1_000_000));
  localparam int REF_CLK_HZ = 100_000_000;

  localparam logic [2:0] OUT_DIV_DEF = 3'h1;
  localparam logic [5:0] REF_DEF = 6'h00;
  localparam logic [11:0] MULT_M00 = 12'h09f;
  localparam logic [11:0] MULT_M11 = 12'h03f;
  localparam logic [11:0] MULT_M10 = 12'h01f;
  localparam logic [11:0] MULT_M01 = 12'h00f;

  localparam logic [3:0] A_PLL = 4'h0;
  localparam logic [3:0] A_STAT = 4'h1;
  localparam logic [3:0] A_SEC = 4'h2;
  localparam logic [3:0] A_CRC = 4'h3;
  localparam logic [3:0] A_SIZE = 4'h4;
  localparam logic [3:0] A_REF_HZ = 4'h5;
  localparam int PLL_REF_LSB = 0;
  localparam int PLL_MULT_LSB = 8;
  localparam int PLL_OUT_DIV_LSB = 23;
  localparam int SEC_BOOT_BIT = 5;

  localparam logic [31:0] CRC_WAIVE = 32'h0d15ab1e;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_SEED = 32'hffffffff;
  localparam logic [15:0] OTP_START = 16'h0000;

  typedef struct packed {
    logic [2:0] out_div;
    logic [11:0] mult;
    logic [5:0] refd;
  } bil_pll_t;

  typedef enum logic [2:0] {
    ST_RST = 3'b000, ST_SEC = 3'b001, ST_SIZE = 3'b011, ST_PROG = 3'b010,
    ST_CHK = 3'b110, ST_RUN = 3'b111, ST_FAIL = 3'b101
  } bil_state_t;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ---- logic/bil_rst_seq.sv ----
`timescale 1ns/1ps
module bil_rst_seq
  import bil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic done
);
  logic [15:0] cnt_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      done <= 1'b0;
    end else if (cnt_r == 16'(RST_SEQ_CYC - 1)) begin
      done <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // bil_rst_seq

// ---- logic/bil_crc.sv ----
`timescale 1ns/1ps
module bil_crc
  import bil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [31:0] crc
);
  logic [31:0] c_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      c_r <= CRC_SEED;
    end else if (clr) begin
      c_r <= CRC_SEED;
    end else if (en) begin
      c_r <= crc_byte(c_r, din);
    end
  end

  assign crc = ~c_r;
endmodule // bil_crc

// ---- logic/bil_loader.sv ----
`timescale 1ns/1ps
module bil_loader
  import bil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] boot_mode,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  input wire logic [31:0] otp_sec_word,
  input wire logic otp_sec_valid,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic src_ready,
  output logic src_otp,
  output logic [15:0] otp_addr,
  output logic gpio_pulldown,
  output logic core_reset,
  output logic ram_we,
  output logic [17:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic exec_start,
  output logic [17:0] exec_addr,
  output logic boot_fail,
  output logic [2:0] pll_out_div,
  output logic [11:0] pll_mult,
  output logic [5:0] pll_ref
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] mode_s1_r;
  logic [1:0] mode_s2_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_r <= 2'h0;
      mode_s2_r <= 2'h0;
    end else begin
      mode_s1_r <= boot_mode;
      mode_s2_r <= mode_s1_r;
    end
  end

  // ----------------------------------------
  // Internal reset sequence
  // ----------------------------------------
  logic seq_done;
  bil_rst_seq u_seq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .done(seq_done)
  );

  // ----------------------------------------
  // PLL setting
  // ----------------------------------------
  // Tile rate = osc * (mult+1)/2 / (ref+1) / (od+1); the PLL itself is analogue.
  bil_pll_t pll_r;
  logic mode_caught_r;

  function automatic logic [11:0] mode_mult(input logic [1:0] m);
    case (m)
      2'b00: return MULT_M00;
      2'b11: return MULT_M11;
      2'b10: return MULT_M10;
      default: return MULT_M01;
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_r <= '{out_div: OUT_DIV_DEF, mult: MULT_M00, refd: REF_DEF};
      mode_caught_r <= 1'b0;
    end else if (!mode_caught_r && seq_done) begin
      // Pins are only latched once the synchroniser has settled after release
      pll_r <= '{out_div: OUT_DIV_DEF, mult: mode_mult(mode_s2_r), refd: REF_DEF};
      mode_caught_r <= 1'b1;
    end else if (reg_wr && reg_addr == A_PLL) begin
      pll_r.refd <= reg_wdata[PLL_REF_LSB +: 6];
      pll_r.mult <= reg_wdata[PLL_MULT_LSB +: 12];
      pll_r.out_div <= reg_wdata[PLL_OUT_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_out_div <= OUT_DIV_DEF;
      pll_mult <= MULT_M00;
      pll_ref <= REF_DEF;
    end else begin
      pll_out_div <= pll_r.out_div;
      pll_mult <= pll_r.mult;
      pll_ref <= pll_r.refd;
    end
  end

  // ----------------------------------------
  // Boot sequencer
  // ----------------------------------------
  bil_state_t st_r;
  logic [31:0] sec_r;
  logic [31:0] size_r;
  logic [31:0] chk_r;
  logic [1:0] bcnt_r;
  logic [31:0] pcnt_r;
  logic [17:0] addr_r;
  logic [31:0] crc_val;
  logic take;
  logic crc_en;

  assign take = src_valid && src_ready;
  assign crc_en = take && (st_r == ST_SIZE || st_r == ST_PROG);

  bil_crc u_crc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(st_r == ST_SEC),
    .en(crc_en),
    .din(src_data),
    .crc(crc_val)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
      sec_r <= 32'h00000000;
      size_r <= 32'h00000000;
      chk_r <= 32'h00000000;
      bcnt_r <= 2'h0;
      pcnt_r <= 32'h00000000;
      addr_r <= 18'h00000;
    end else begin
      unique case (st_r)
        // Held until release and sequence end
        ST_RST: if (seq_done && mode_caught_r) begin
          st_r <= ST_SEC;
        end
        ST_SEC: if (otp_sec_valid) begin
          sec_r <= otp_sec_word;
          bcnt_r <= 2'h0;
          st_r <= ST_SIZE;
        end
        ST_SIZE: if (take) begin
          size_r <= {src_data, size_r[31:8]};
          bcnt_r <= bcnt_r + 2'h1;
          if (bcnt_r == 2'h3) begin
            pcnt_r <= {24'h000000, src_data} << 24 | (size_r >> 8);
            addr_r <= 18'h00000;
            st_r <= ({src_data, size_r[31:8]} == 32'h00000000) ? ST_CHK : ST_PROG;
          end
        end
        ST_PROG: if (take) begin
          addr_r <= addr_r + 18'h00001;
          bcnt_r <= bcnt_r + 2'h1;
          if (bcnt_r == 2'h3) begin
            pcnt_r <= pcnt_r - 32'h00000001;
            if (pcnt_r == 32'h00000001) begin
              st_r <= ST_CHK;
            end
          end
        end
        ST_CHK: if (take) begin
          chk_r <= {src_data, chk_r[31:8]};
          bcnt_r <= bcnt_r + 2'h1;
          if (bcnt_r == 2'h3) begin
            if ({src_data, chk_r[31:8]} == CRC_WAIVE ||
                {src_data, chk_r[31:8]} == crc_val) begin
              st_r <= ST_RUN;
            end else begin
              st_r <= ST_FAIL;
            end
          end
        end
        ST_RUN: st_r <= ST_RUN;
        ST_FAIL: st_r <= ST_FAIL;
        default: st_r <= ST_RST;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_ready <= 1'b0;
      src_otp <= 1'b0;
      otp_addr <= OTP_START;
      gpio_pulldown <= 1'b1;
      core_reset <= 1'b1;
      ram_we <= 1'b0;
      ram_addr <= 18'h00000;
      ram_wdata <= 8'h00;
      exec_start <= 1'b0;
      exec_addr <= 18'h00000;
      boot_fail <= 1'b0;
    end else begin
      // Ready is registered, so a byte may be taken one cycle after the state ends;
      // states drop it on every fourth byte taken (bcnt_r of 3) to avoid that overrun.
      src_ready <= (st_r == ST_SIZE || st_r == ST_PROG || st_r == ST_CHK) &&
                   !(take && bcnt_r == 2'h3);
      // Flash by default, bit 5 selects OTP
      src_otp <= sec_r[SEC_BOOT_BIT];
      // Secure boot from OTP address 0
      if (st_r == ST_SEC) begin
        otp_addr <= OTP_START;
      end else if (take && src_otp) begin
        otp_addr <= otp_addr + 16'h0001;
      end
      gpio_pulldown <= (st_r == ST_RST);
      core_reset <= (st_r != ST_RUN);
      ram_we <= take && st_r == ST_PROG;
      ram_addr <= addr_r;
      ram_wdata <= src_data;
      exec_start <= (st_r == ST_RUN) && !exec_start && core_reset;
      exec_addr <= 18'h00000;
      boot_fail <= (st_r == ST_FAIL);
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        A_PLL: reg_rdata <= {6'h00, pll_r.out_div, 3'h0, pll_r.mult, 2'h0, pll_r.refd};
        A_STAT: reg_rdata <= {24'h000000, 1'b0, st_r, src_otp, boot_fail,
                              !core_reset, seq_done};
        A_SEC: reg_rdata <= sec_r;
        A_CRC: reg_rdata <= crc_val;
        A_SIZE: reg_rdata <= size_r;
        A_REF_HZ: reg_rdata <= 32'(REF_CLK_HZ);
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // bil_loader

// ---- sim/bil_loader_assertions.sv ----
`timescale 1ns/1ps
module bil_loader_assertions
  import bil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic src_valid,
  input wire logic src_ready,
  input wire logic src_otp,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic core_reset,
  input wire logic ram_we,
  input wire logic exec_start,
  input wire logic boot_fail,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] otp_addr,
  input wire logic [17:0] ram_addr,
  input wire logic [17:0] exec_addr,
  input wire logic [2:0] pll_out_div,
  input wire logic [11:0] pll_mult,
  input wire logic [5:0] pll_ref
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Writes since reset give the address each byte must land on
  logic [17:0] wr_cnt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wr_cnt_r <= 18'h0;
    else if (ram_we) wr_cnt_r <= wr_cnt_r + 18'h1;
  end
  // PLL outputs trail a write by two edges, so the data is kept that long
  logic [31:0] wd1_r;
  logic [31:0] wd2_r;
  logic pll_wr_d_r;
  always_ff @(posedge clk_sys) begin
    wd1_r <= reg_wdata;
    wd2_r <= wd1_r;
    pll_wr_d_r <= reg_wr && reg_addr == A_PLL;
  end
  property p_ram_seq; ram_we |-> ram_addr == wr_cnt_r; endproperty
  a_ram_seq: assert property (p_ram_seq) else $error("ram address out of order");
  property p_run_start; $fell(core_reset) |-> ##[0:1] (exec_start && exec_addr == 18'h0);
  endproperty
  a_run_start: assert property (p_run_start) else $error("no start at zero");
  property p_fail_hold; boot_fail |-> (core_reset && !exec_start) ##1 boot_fail; endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("failed boot ran");
  property p_otp_step;
    src_otp && src_valid && src_ready |=> otp_addr == $past(otp_addr) + 16'h1;
  endproperty
  a_otp_step: assert property (p_otp_step) else $error("otp address step");
  property p_pll_wr;
    reg_wr && reg_addr == A_PLL && !core_reset |=> ##1
      {pll_out_div, pll_mult, pll_ref} == {wd2_r[25:23], wd2_r[19:8], wd2_r[5:0]};
  endproperty
  a_pll_wr: assert property (p_pll_wr) else $error("pll write lost");
  property p_pll_keep;
    !core_reset && !(reg_wr && reg_addr == A_PLL) && !pll_wr_d_r |=>
    $stable(pll_out_div) && $stable(pll_mult) && $stable(pll_ref);
  endproperty
  a_pll_keep: assert property (p_pll_keep) else $error("pll changed alone");
  property p_rd_pll; reg_rd && reg_addr == A_PLL |=>
    reg_rdata == {6'h0, pll_out_div, 3'h0, pll_mult, 2'h0, pll_ref};
  endproperty
  a_rd_pll: assert property (p_rd_pll) else $error("pll read wrong");
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // bil_loader_assertions

bind bil_loader bil_loader_assertions bil_loader_assertions_i (
  .clk_sys, .rst_n, .src_valid, .src_ready, .src_otp, .reg_wr, .reg_rd, .core_reset,
  .ram_we, .exec_start, .boot_fail, .reg_addr, .reg_wdata, .reg_rdata, .otp_addr,
  .ram_addr, .exec_addr, .pll_out_div, .pll_mult, .pll_ref
);

// ---- sim/bil_img_src.sv ----
`timescale 1ns/1ps
module bil_img_src (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic src_ready,
  output logic src_valid,
  output logic [7:0] src_data,
  output logic [31:0] otp_sec_word,
  output logic otp_sec_valid
);
  logic [7:0] img [0:63];
  logic [31:0] sec_word = 32'h0;
  logic slow = 1'b0;
  int len = 0, pos = 0;
  // security word offered once reset lifts
  assign otp_sec_word = sec_word;
  assign otp_sec_valid = rst_n;
  initial src_valid = 1'b0;
  initial src_data = 8'h5a;
  // bytes in image order, held until taken; idle data keeps toggling
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 0;
      src_valid <= 1'b0;
    end else if (src_valid && src_ready) begin
      pos <= pos + 1;
      src_valid <= !slow && pos + 1 < len;
      src_data <= (!slow && pos + 1 < len) ? img[pos + 1] : ~src_data;
    end else if (!src_valid && pos < len) begin
      src_valid <= 1'b1;
      src_data <= img[pos];
    end else if (!src_valid) begin
      src_data <= ~src_data;
    end
  end
endmodule // bil_img_src

// ---- sim/test_bil_loader.sv ----
`timescale 1ns/1ps
module test_bil_loader;
  import bil_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] boot_mode = 2'b00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, otp_sec_word, reg_rdata;
  logic src_valid, otp_sec_valid, src_ready, src_otp, gpio_pulldown, core_reset;
  logic ram_we, exec_start, boot_fail;
  logic [7:0] src_data, ram_wdata;
  logic [7:0] ram [0:63];
  logic [15:0] otp_addr;
  logic [17:0] ram_addr, exec_addr;
  logic [2:0] pll_out_div;
  logic [11:0] pll_mult;
  logic [5:0] pll_ref;
  logic [11:0] mult_tab [4] = '{12'h09f, 12'h00f, 12'h01f, 12'h03f};
  int n_fail = 0, checks_done = 0;
  always #10 clk_sys = ~clk_sys;
  bil_loader bil_loader_i (
    .clk_sys, .rst_n, .boot_mode, .src_valid, .src_data, .otp_sec_word, .otp_sec_valid,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_ready, .src_otp, .otp_addr,
    .gpio_pulldown, .core_reset, .ram_we, .ram_addr, .ram_wdata, .exec_start, .exec_addr,
    .boot_fail, .pll_out_div, .pll_mult, .pll_ref
  );
  bil_img_src bil_img_src_i (
    .clk_sys, .rst_n, .src_ready, .src_valid, .src_data, .otp_sec_word, .otp_sec_valid
  );
  always @(posedge clk_sys) if (ram_we === 1'b1) ram[ram_addr[5:0]] <= ram_wdata;
  // ------
  // Tasks
  // ------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One register access; read data is looked at just after the edge that launches it
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= w ? d : 32'h0;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!w) chk("reg_rdata", reg_rdata, d);
  endtask
  task automatic boot(input logic [1:0] m, input logic otp, input logic [31:0] nw, input int kind);
    logic [31:0] c, ck;
    int i, k, t_rdy;
    c = CRC_SEED;
    for (i = 0; i < 4 + 4 * nw; i++) begin
      bil_img_src_i.img[i] = (i < 4) ? nw[8 * i +: 8] : 8'(i * 37 + m);
      for (k = 0; k < 8; k++) c = (c[0] ^ bil_img_src_i.img[i][k]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    ck = (kind == 1) ? CRC_WAIVE : (~c ^ 32'(kind == 2));
    for (i = 0; i < 4; i++) bil_img_src_i.img[4 + 4 * nw + i] = ck[8 * i +: 8];
    bil_img_src_i.len = 8 + 4 * nw;
    bil_img_src_i.sec_word = 32'(otp) << SEC_BOOT_BIT;
    bil_img_src_i.slow = otp;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    // mode pins move only while reset is held, then stay
    boot_mode <= m;
    repeat (3) @(posedge clk_sys);
    chk("gpio_pulldown", gpio_pulldown, 1);
    chk("core_reset", core_reset, 1);
    chk("pll_reset", {pll_out_div, pll_mult, pll_ref}, {3'h1, 12'h09f, 6'h00});
    rst_n <= 1'b1;
    t_rdy = 0;
    for (i = 0; i < 4000 && exec_start !== 1'b1 && boot_fail !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
      if (t_rdy == 0 && src_ready === 1'b1) t_rdy = i;
    end
    if (i == 4000) begin
      n_fail++;
      print_verdict();
    end
    chk("boot_delay", 32'(t_rdy >= 750 && t_rdy <= 7500), 1);
    chk("exec_start", exec_start, 32'(kind != 2));
    chk("boot_fail", boot_fail, 32'(kind == 2));
    chk("core_reset", core_reset, 32'(kind == 2));
    chk("gpio_pulldown", gpio_pulldown, 0);
    chk("exec_addr", exec_addr, 0);
    chk("pll_mult", pll_mult, mult_tab[m]);
    chk("src_otp", src_otp, otp);
    if (otp) chk("otp_addr", otp_addr, 8 + 4 * nw);
    for (i = 0; i < 4 * nw; i++) chk("ram", ram[i], bil_img_src_i.img[4 + i]);
  endtask
  initial begin
    boot(2'b00, 1'b0, 32'h2, 0);
    acc(1'b0, A_PLL, 32'h0080_9f00);
    acc(1'b0, A_SIZE, 32'h2);
    acc(1'b1, A_PLL, 32'h0101_2305);
    acc(1'b0, A_PLL, 32'h0101_2305);
    chk("pll_ports", {pll_out_div, pll_mult, pll_ref}, {3'h2, 12'h123, 6'h05});
    acc(1'b0, 4'hf, 32'h0);
    acc(1'b0, A_REF_HZ, 32'h05f5_e100);
    boot(2'b11, 1'b1, 32'h1, 1);
    boot(2'b10, 1'b0, 32'h3, 2);
    boot(2'b01, 1'b1, 32'h0, 0);
    print_verdict();
  end
endmodule // test_bil_loader
